// file: design/pbr_ltn_count.sv
// Remaining word counter that derives the last-transfer-next flag.
`timescale 1ns/10ps
module pbr_ltn_count
  import pbr_pkg::*;
(
  input  wire logic                 core_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 load_in,
  input  wire logic [PBR_CNT_W-1:0] words_in,
  input  wire logic                 take_in,
  input  wire logic                 stop_in,
  output logic                      last_transfer_next_out
);

  logic [PBR_CNT_W-1:0] remaining;
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      remaining <= PBR_CNT_RST;
    end else if (load_in) begin
      remaining <= words_in;
    end else if (take_in && remaining != PBR_CNT_RST) begin
      remaining <= remaining - PBR_CNT_ONE;
    end
  end
  // A word taken in this cycle already counts, so the flag never lags a phase.
  assign last_transfer_next_out = (remaining <= PBR_CNT_ONE) || stop_in ||
                                  (take_in && (remaining - PBR_CNT_ONE) == PBR_CNT_ONE);

endmodule

// file: design/pbr_port_fsm.sv
// Burst read control state machine of the first DMA port, with command slots.
// ---------------------------------------------------------------------------
// Functional notes
// - Request low while a command is active; queued request low when another waits.
// - Direction output tells the arbiter whether the pending transfer reads or writes.
// - Transfer request is withdrawn during Last Transfer.
// - At the end of Clean Up the request returns if a queued command exists.
// - Last-transfer-next flag comes from remaining count, high when next state is final.
// - The bus is in one of address out, data in, data ignored, released.
// - Sample strobe low only in data-input condition; data captured while it is low.
// - Final-cycle strobe low during Last Transfer only.
// - Select and ready both low at start enter Address 1 and drive the address.
// - Address 1 then select high, ready low inserts released turnaround without sampling.
// - Data Read goes to Data Read, Last Transfer or Data Wait by ready and flag.
// - From Data Read, low/high gives tri-state; low/low gives an address cycle.
// - Data Wait ignores the bus, strobe high; high/high stays in Data Wait.
// - From Data Wait, ready low goes to Data Read or Last Transfer by flag.
// - From Data Wait, low/high gives tri-state; low/low gives an address cycle.
// - Select low with ready high releases all outputs and remembers one of eight origins.
// - Four tri-state variants leave to Data Read or Last Transfer by the flag.
// - Last Transfer is followed by Clean Up, strobes and request high there.
// - Leaving Address 1 with no request asserted goes to turnaround wait instead.
// - Early stop ends the transfer once the next data phase completes.
// ---------------------------------------------------------------------------
`timescale 1ns/10ps
module pbr_port_fsm
  import pbr_pkg::*;
(
  input  wire logic                core_clk_in,
  input  wire logic                reset_in,
  input  wire logic                cmd_valid_in,
  input  wire pbr_cmd_t            cmd_in,
  output logic                     cmd_ready_out,
  output logic                     transfer_request_n_out,
  output logic                     queued_request_n_out,
  output logic                     dir_read_out,
  input  wire logic                addr_data_select_n_in,
  input  wire logic                target_ready_n_in,
  input  wire logic                comm_register_select_in,
  input  wire logic                early_stop_n_in,
  input  wire logic [PBR_AD_W-1:0] port_addr_data_bus_in,
  output logic [PBR_AD_W-1:0]      port_addr_data_bus_out,
  output logic                     port_addr_data_bus_oe_out,
  output logic                     sample_strobe_n_out,
  output logic                     final_strobe_n_out,
  output logic                     rd_valid_out,
  output logic [PBR_BUF_W-1:0]     rd_data_out,
  input  wire logic                rd_ready_in
);

  // ---------------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------------
  pbr_state_t    state;
  pbr_state_t    next_state;
  pbr_origin_t   origin;
  pbr_origin_t   next_origin;
  pbr_cmd_t      act_cmd;
  pbr_cmd_t      que_cmd;
  logic          act_valid;
  logic          que_valid;
  logic          post_turn;
  logic          busy;
  logic          stop_seen;
  logic          ltn;
  logic          room_next;
  logic          capture;
  logic          cmd_take;
  logic          promote;
  logic          sel_n;
  logic          rdy_n;
  logic [15:0]   addr_low;
  pbr_bus_out_t  next_bus;

  assign sel_n    = addr_data_select_n_in;
  assign rdy_n    = target_ready_n_in;
  // Data on the bus is taken at the edge that closes a cycle with the strobe low.
  assign capture  = !sample_strobe_n_out;
  assign cmd_take = cmd_valid_in && cmd_ready_out;
  assign promote  = (state == PBR_LTX);

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic pbr_origin_t origin_of(input pbr_state_t s, input pbr_origin_t keep);
    pbr_origin_t o;
    o = keep;
    case (s)
      PBR_AD1: o = PBR_FROM_AD1;
      PBR_AD2: o = PBR_FROM_AD2;
      PBR_ATA: o = PBR_FROM_ATA;
      PBR_DRD: o = PBR_FROM_DRD;
      PBR_DWT: o = PBR_FROM_DWT;
      PBR_LTX: o = PBR_FROM_LTX;
      PBR_CUP: o = PBR_FROM_CUP;
      PBR_ATW: o = PBR_FROM_ATW;
      default: o = keep;
    endcase
    return o;
  endfunction

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  // The register select input is not decoded here; DMA states rely on it staying low.
  // Sequencing of select and ready is the arbiter's duty; the table below follows it.
  always_comb begin
    next_state  = state;
    next_origin = origin;
    if (state == PBR_IDLE) begin
      if (!sel_n && !rdy_n) begin
        next_state = PBR_AD1;
      end
    end else if (!sel_n && rdy_n) begin
      next_state  = PBR_TRI;
      next_origin = origin_of(state, origin);
    end else if (!sel_n && !rdy_n) begin
      // Address cycles after the turnaround are Address 2.
      next_state = post_turn ? PBR_AD2 : PBR_AD1;
    end else if (!rdy_n) begin
      case (state)
        PBR_AD1: begin
          next_state = transfer_request_n_out ? PBR_ATW : PBR_ATA;
        end
        PBR_ATW: begin
          next_state = PBR_ATA;
        end
        PBR_LTX: begin
          next_state = PBR_CUP;
        end
        PBR_CUP: begin
          next_state = PBR_ATW;
        end
        PBR_TRI: begin
          if (origin == PBR_FROM_LTX || origin == PBR_FROM_CUP) begin
            next_state = (origin == PBR_FROM_LTX) ? PBR_ATW : PBR_ATA;
          end else if (origin == PBR_FROM_AD1 || origin == PBR_FROM_ATW) begin
            next_state = PBR_ATA;
          end else begin
            next_state = (ltn && room_next) ? PBR_LTX : PBR_DRD;
          end
        end
        default: begin
          next_state = (ltn && room_next) ? PBR_LTX : PBR_DRD;
        end
      endcase
    end else begin
      case (state)
        PBR_AD1, PBR_ATW: begin
          next_state = PBR_ATW;
        end
        PBR_LTX: begin
          next_state = PBR_CUP;
        end
        PBR_TRI: begin
          if (origin == PBR_FROM_AD1 || origin == PBR_FROM_ATW) begin
            next_state = PBR_ATW;
          end else begin
            next_state = PBR_DWT;
          end
        end
        default: begin
          next_state = PBR_DWT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // State registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state  <= PBR_IDLE;
      origin <= PBR_FROM_AD1;
    end else begin
      state  <= next_state;
      origin <= next_origin;
    end
  end

  // Pre and post turnaround phase; Address 1 versus Address 2 hinges on it.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      post_turn <= 1'b0;
    end else if (next_state == PBR_ATA) begin
      post_turn <= 1'b1;
    end else if (next_state == PBR_LTX) begin
      post_turn <= 1'b0;
    end
  end

  // Early stop is held until the final phase so a one-cycle pulse is not missed.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      stop_seen <= 1'b0;
    end else if (state == PBR_LTX) begin
      stop_seen <= 1'b0;
    end else if (!early_stop_n_in && busy) begin
      stop_seen <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Command slots
  // ---------------------------------------------------------------------------
  // A new command may arrive while the active one is promoted; both paths land safely.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      act_valid <= 1'b0;
      que_valid <= 1'b0;
      act_cmd   <= '0;
      que_cmd   <= '0;
    end else if (promote) begin
      act_valid <= que_valid || cmd_take;
      act_cmd   <= que_valid ? que_cmd : cmd_in;
      que_valid <= que_valid && cmd_take;
      if (que_valid && cmd_take) begin
        que_cmd <= cmd_in;
      end
    end else if (cmd_take) begin
      if (!act_valid) begin
        act_valid <= 1'b1;
        act_cmd   <= cmd_in;
      end else begin
        que_valid <= 1'b1;
        que_cmd   <= cmd_in;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      busy <= 1'b0;
    end else if (next_state == PBR_AD1) begin
      busy <= 1'b1;
    end else if (state == PBR_CUP) begin
      busy <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // Request lines
  // ---------------------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      transfer_request_n_out <= PBR_REQ_N_RST;
      queued_request_n_out   <= PBR_REQ_N_RST;
      dir_read_out           <= 1'b0;
      cmd_ready_out          <= 1'b0;
    end else begin
      if (next_state == PBR_LTX || next_state == PBR_CUP) begin
        transfer_request_n_out <= 1'b1;
      end else if (state == PBR_CUP) begin
        transfer_request_n_out <= !act_valid;
      end else if (!busy && act_valid) begin
        transfer_request_n_out <= 1'b0;
      end
      queued_request_n_out <= !que_valid;
      dir_read_out         <= act_cmd.is_read;
      cmd_ready_out        <= !que_valid && !(act_valid && cmd_take);
    end
  end

  // ---------------------------------------------------------------------------
  // Bus, strobes and address counter
  // ---------------------------------------------------------------------------
  // The low half steps and wraps inside its 64K window, as the port expects.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      addr_low <= '0;
    end else if (next_state == PBR_AD1 && state != PBR_AD1) begin
      addr_low <= act_cmd.addr[15:0];
    end else if (capture) begin
      addr_low <= addr_low + PBR_ADDR_STEP;
    end
  end

  always_comb begin
    next_bus.oe   = (next_state == PBR_AD1) || (next_state == PBR_AD2);
    next_bus.data = (next_state == PBR_AD1) ? act_cmd.addr
                                            : {act_cmd.addr[31:16], addr_low};
  end

  // Outputs follow the state being entered; data-in states alone sample.
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      port_addr_data_bus_oe_out <= 1'b0;
      port_addr_data_bus_out    <= PBR_AD_RST;
      sample_strobe_n_out       <= PBR_STROBE_N_RST;
      final_strobe_n_out        <= PBR_STROBE_N_RST;
    end else begin
      port_addr_data_bus_oe_out <= next_bus.oe;
      port_addr_data_bus_out    <= next_bus.data;
      // A full buffer keeps the strobe high and delays Last Transfer, so no word is lost.
      sample_strobe_n_out <= !(((next_state == PBR_DRD) || (next_state == PBR_LTX))
                               && room_next);
      final_strobe_n_out  <= (next_state != PBR_LTX);
    end
  end

  // ---------------------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------------------
  pbr_ltn_count u_ltn (
    .core_clk_in            (core_clk_in),
    .reset_in               (reset_in),
    .load_in                (next_state == PBR_AD1 && state != PBR_AD1),
    .words_in               (act_cmd.words),
    .take_in                (capture),
    .stop_in                (stop_seen || !early_stop_n_in),
    .last_transfer_next_out (ltn)
  );

  pbr_skid_buf #(
    .W (PBR_BUF_W)
  ) u_buf (
    .core_clk_in   (core_clk_in),
    .reset_in      (reset_in),
    .in_valid_in   (capture),
    .in_data_in    (port_addr_data_bus_in),
    .in_ready_out  (),
    .room_next_out (room_next),
    .out_valid_out (rd_valid_out),
    .out_data_out  (rd_data_out),
    .out_ready_in  (rd_ready_in)
  );

endmodule

// file: design/pbr_skid_buf.sv
// Two-entry buffer between the sampled bus data and the user read port.
`timescale 1ns/10ps
module pbr_skid_buf
  import pbr_pkg::*;
#(
  parameter int unsigned W = PBR_BUF_W
) (
  input  wire logic         core_clk_in,
  input  wire logic         reset_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              room_next_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);

  logic [W-1:0] tail_data;
  logic         tail_valid;
  logic         push;
  logic         pop;
  logic         next_tail_valid;

  assign in_ready_out  = !tail_valid;
  assign push          = in_valid_in && !tail_valid;
  assign pop           = out_valid_out && out_ready_in;
  // Room for one more word after this edge; the sampler looks one cycle ahead.
  assign room_next_out = !next_tail_valid;

  always_comb begin
    next_tail_valid = tail_valid;
    if (pop) begin
      next_tail_valid = tail_valid && push;
    end else if (push && out_valid_out) begin
      next_tail_valid = 1'b1;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      out_valid_out <= 1'b0;
      tail_valid    <= 1'b0;
      out_data_out  <= '0;
      tail_data     <= '0;
    end else begin
      tail_valid <= next_tail_valid;
      if (pop) begin
        out_valid_out <= tail_valid || push;
        out_data_out  <= tail_valid ? tail_data : in_data_in;
        if (tail_valid && push) begin
          tail_data <= in_data_in;
        end
      end else if (push) begin
        if (!out_valid_out) begin
          out_valid_out <= 1'b1;
          out_data_out  <= in_data_in;
        end else begin
          tail_data <= in_data_in;
        end
      end
    end
  end

endmodule

// file: shared/pbr_pkg.sv
// Package with the types and constants of the port burst read state machine.
package pbr_pkg;

  // ---------------------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------------------
  localparam int unsigned PBR_AD_W    = 32;
  localparam int unsigned PBR_CNT_W   = 16;
  localparam int unsigned PBR_BUF_W   = 32;

  // ---------------------------------------------------------------------------
  // Address stepping and reset values
  // ---------------------------------------------------------------------------
  localparam logic [15:0]          PBR_ADDR_STEP     = 16'h0004;
  localparam logic [PBR_CNT_W-1:0] PBR_CNT_ONE       = 16'h0001;
  localparam logic [PBR_CNT_W-1:0] PBR_CNT_RST       = 16'h0000;
  localparam logic [PBR_AD_W-1:0]  PBR_AD_RST        = 32'h0000_0000;
  localparam logic                 PBR_STROBE_N_RST  = 1'b1;
  localparam logic                 PBR_REQ_N_RST     = 1'b1;

  // ---------------------------------------------------------------------------
  // State machine states, one-hot
  // ---------------------------------------------------------------------------
  typedef enum logic [9:0] {
    PBR_IDLE = 10'h001,
    PBR_AD1  = 10'h002,
    PBR_ATA  = 10'h004,
    PBR_ATW  = 10'h008,
    PBR_AD2  = 10'h010,
    PBR_DRD  = 10'h020,
    PBR_DWT  = 10'h040,
    PBR_LTX  = 10'h080,
    PBR_CUP  = 10'h100,
    PBR_TRI  = 10'h200
  } pbr_state_t;

  // Origin of a tri-state condition, one of eight.
  typedef enum logic [2:0] {
    PBR_FROM_AD1 = 3'h0,
    PBR_FROM_AD2 = 3'h1,
    PBR_FROM_ATA = 3'h2,
    PBR_FROM_DRD = 3'h3,
    PBR_FROM_DWT = 3'h4,
    PBR_FROM_LTX = 3'h5,
    PBR_FROM_CUP = 3'h6,
    PBR_FROM_ATW = 3'h7
  } pbr_origin_t;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [PBR_AD_W-1:0]  addr;
    logic [PBR_CNT_W-1:0] words;
    logic                 is_read;
  } pbr_cmd_t;

  typedef struct packed {
    logic [PBR_AD_W-1:0] data;
    logic                oe;
  } pbr_bus_out_t;

endpackage

// file: verif/pbr_arb_model.sv
// Model of the external arbiter that steps select and ready and sources read data.
`timescale 1ns/10ps
module pbr_arb_model
  import pbr_pkg::*;
#(
  parameter logic [31:0] WBASE = 32'h5A00_0000
) (
  input  wire logic          core_clk_in,
  input  wire logic          reset_in,
  input  wire logic          transfer_request_n_in,
  input  wire logic          sample_strobe_n_in,
  input  wire logic          final_strobe_n_in,
  input  wire logic          bus_oe_in,
  input  wire logic [31:0]   bus_drv_in,
  input  wire logic          stall_in,
  input  wire logic          tri_in,
  output logic               addr_data_select_n_out,
  output logic               target_ready_n_out,
  output logic [31:0]        bus_out
);
  logic [31:0] idx;
  logic [1:0]  ph;
  // Off-phase data is inverted so a stale capture cannot pass for a good word.
  assign bus_out = bus_oe_in ? bus_drv_in :
                   (sample_strobe_n_in ? ~(WBASE + idx) : (WBASE + idx));

  always @(posedge core_clk_in) begin
    if (reset_in) begin
      idx <= 32'h0000_0000;
    end else if (!sample_strobe_n_in) begin
      idx <= idx + 32'h0000_0001;
    end
  end

  always @(negedge core_clk_in) begin
    if (reset_in) begin
      addr_data_select_n_out <= 1'b0;
      target_ready_n_out     <= 1'b1;
      ph                     <= 2'h0;
    end else begin
      case (ph)
        2'h0: if (!transfer_request_n_in) begin
          addr_data_select_n_out <= 1'b0;
          target_ready_n_out     <= 1'b0;
          ph                     <= 2'h1;
        end
        2'h1: if (!final_strobe_n_in) begin
          addr_data_select_n_out <= 1'b1;
          target_ready_n_out     <= 1'b0;
          ph                     <= 2'h2;
        end else begin
          addr_data_select_n_out <= ~tri_in;
          target_ready_n_out     <= stall_in | tri_in;
        end
        default: begin
          addr_data_select_n_out <= 1'b0;
          target_ready_n_out     <= 1'b1;
          ph                     <= 2'h0;
        end
      endcase
    end
  end
endmodule

// file: verif/pbr_port_fsm_props.sv
// Checker of the port burst read state machine, bound to its top module.
`timescale 1ns/10ps
module pbr_port_fsm_props
  import pbr_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic transfer_request_n_out,
  input wire logic queued_request_n_out,
  input wire logic addr_data_select_n_in,
  input wire logic target_ready_n_in,
  input wire logic port_addr_data_bus_oe_out,
  input wire logic sample_strobe_n_out,
  input wire logic final_strobe_n_out
);
  // ---------------------------------------------------------------------------
  // Helper: set once the transfer has passed its turnaround
  // ---------------------------------------------------------------------------
  logic post_turn;
  always_ff @(posedge core_clk_in) begin
    if (reset_in || !final_strobe_n_out) begin
      post_turn <= 1'b0;
    end else if (!sample_strobe_n_out ||
                 (port_addr_data_bus_oe_out && addr_data_select_n_in && !target_ready_n_in)) begin
      post_turn <= 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);

  property p_final_one;
    !final_strobe_n_out |=> final_strobe_n_out && sample_strobe_n_out;
  endproperty
  a_final_one: assert property (p_final_one) else $error("final strobe not one cycle");
  property p_req_off;
    $fell(final_strobe_n_out) |-> transfer_request_n_out;
  endproperty
  a_req_off: assert property (p_req_off) else $error("request held in last transfer");
  property p_strobe_in;
    !sample_strobe_n_out |-> !port_addr_data_bus_oe_out;
  endproperty
  a_strobe_in: assert property (p_strobe_in) else $error("strobe while driving bus");
  property p_addr;
    !addr_data_select_n_in && !target_ready_n_in |=>
      port_addr_data_bus_oe_out && sample_strobe_n_out && final_strobe_n_out;
  endproperty
  a_addr: assert property (p_addr) else $error("no address cycle");
  property p_tri;
    !addr_data_select_n_in && target_ready_n_in |=>
      !port_addr_data_bus_oe_out && sample_strobe_n_out && final_strobe_n_out;
  endproperty
  a_tri: assert property (p_tri) else $error("outputs not released");
  property p_turn;
    port_addr_data_bus_oe_out && addr_data_select_n_in && !target_ready_n_in && !post_turn
      |=> !port_addr_data_bus_oe_out && sample_strobe_n_out;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround missing");
  property p_wait;
    !sample_strobe_n_out && final_strobe_n_out && addr_data_select_n_in && target_ready_n_in
      |=> sample_strobe_n_out && !port_addr_data_bus_oe_out;
  endproperty
  a_wait: assert property (p_wait) else $error("data wait missing");
  property p_queued;
    !queued_request_n_out && final_strobe_n_out && $past(final_strobe_n_out)
      |-> !transfer_request_n_out;
  endproperty
  a_queued: assert property (p_queued) else $error("queued without active request");
  property p_rearm;
    $rose(final_strobe_n_out) && !$past(queued_request_n_out, 2) |=> !transfer_request_n_out;
  endproperty
  a_rearm: assert property (p_rearm) else $error("request not renewed");

  c_last: cover property (!final_strobe_n_out);
  c_wait: cover property (!sample_strobe_n_out && addr_data_select_n_in && target_ready_n_in);
  c_tri: cover property (!addr_data_select_n_in && target_ready_n_in && !transfer_request_n_out);
  c_queue: cover property (!queued_request_n_out);
endmodule

bind pbr_port_fsm pbr_port_fsm_props i_props (
  .core_clk_in(core_clk_in), .reset_in(reset_in),
  .transfer_request_n_out(transfer_request_n_out), .queued_request_n_out(queued_request_n_out),
  .addr_data_select_n_in(addr_data_select_n_in), .target_ready_n_in(target_ready_n_in),
  .port_addr_data_bus_oe_out(port_addr_data_bus_oe_out),
  .sample_strobe_n_out(sample_strobe_n_out), .final_strobe_n_out(final_strobe_n_out)
);

// file: verif/pbr_port_fsm_tb_top.sv
// Self-checking testbench of the port burst read state machine.
`timescale 1ns/10ps
module pbr_port_fsm_tb_top
  import pbr_pkg::*;
();
  localparam logic [31:0] WBASE = 32'h5A00_0000;
  logic        core_clk_in, reset_in, cmd_valid_in, rd_ready_in, stall, tri_go, hold;
  logic        cmd_ready, req_n, qreq_n, dir_rd, sel_n, rdy_n, oe, s_n, f_n, rd_valid, took, oe_q;
  logic [31:0] bus_in, dut_bus, rd_data, rnd, seed, nword;
  pbr_cmd_t    cmd_in;
  pbr_cmd_t    cq[$];
  logic [31:0] exp_addr[$];
  logic [31:0] exp_data[$];
  int          n_mismatch, total_checks;

  pbr_port_fsm i_dut (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .cmd_valid_in(cmd_valid_in),
    .cmd_in(cmd_in), .cmd_ready_out(cmd_ready), .transfer_request_n_out(req_n),
    .queued_request_n_out(qreq_n), .dir_read_out(dir_rd), .addr_data_select_n_in(sel_n),
    .target_ready_n_in(rdy_n), .comm_register_select_in(1'b0),
    .early_stop_n_in(1'b1), .port_addr_data_bus_in(bus_in), .port_addr_data_bus_out(dut_bus),
    .port_addr_data_bus_oe_out(oe), .sample_strobe_n_out(s_n), .final_strobe_n_out(f_n),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .rd_ready_in(rd_ready_in)
  );
  pbr_arb_model #(.WBASE(WBASE)) i_arb (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .transfer_request_n_in(req_n),
    .sample_strobe_n_in(s_n), .final_strobe_n_in(f_n), .bus_oe_in(oe), .bus_drv_in(dut_bus),
    .stall_in(stall), .tri_in(tri_go), .addr_data_select_n_out(sel_n),
    .target_ready_n_out(rdy_n), .bus_out(bus_in)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  task automatic chk_bit(input string nm, input logic e, input logic g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Clock, random inputs, command driver, monitor, watchdog
  // ---------------------------------------------------------------------------
  initial begin
    core_clk_in = 1'b0;
    forever #10 core_clk_in = ~core_clk_in;
  end
  initial begin
    rnd = 32'h8f897b4d;
    {stall, tri_go, rd_ready_in} = 3'h0;
    forever begin
      @(negedge core_clk_in);
      rnd = xs(rnd);
      stall = (rnd[1:0] == 2'h0);
      tri_go = (rnd[4:2] == 3'h0);
      rd_ready_in = (rnd[9:8] != 2'h0) && !hold;
    end
  end
  // Expectations are noted when a command is taken, so the order matches the read stream.
  initial begin
    cmd_valid_in = 1'b0;
    cmd_in = '0;
    nword = WBASE;
    forever begin
      @(posedge core_clk_in);
      took = cmd_valid_in && cmd_ready;
      @(negedge core_clk_in);
      if (took) begin
        exp_addr.push_back(cq[0].addr);
        repeat ((cq[0].words == 16'h0000) ? 1 : cq[0].words) begin
          exp_data.push_back(nword);
          nword++;
        end
        void'(cq.pop_front());
      end
      cmd_valid_in = (cq.size() != 0);
      if (cq.size() != 0) cmd_in = cq[0];
    end
  end
  always @(posedge core_clk_in) begin
    if (!reset_in && rd_valid && rd_ready_in) chk_word("rd_data", exp_data.pop_front(), rd_data);
    if (!reset_in && oe && !oe_q) chk_word("addr", exp_addr.pop_front(), dut_bus);
    oe_q = oe;
  end
  initial begin
    repeat (60000) @(posedge core_clk_in);
    n_mismatch++;
    end_sim();
  end

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    reset_in = 1'b1;
    hold = 1'b0;
    oe_q = 1'b0;
    n_mismatch = 0;
    total_checks = 0;
    repeat (5) @(negedge core_clk_in);
    chk_bit("oe", 1'b0, oe);
    chk_bit("sample_strobe_n", 1'b1, s_n);
    chk_bit("final_strobe_n", 1'b1, f_n);
    chk_bit("request_n", 1'b1, req_n);
    @(negedge core_clk_in);
    reset_in = 1'b0;
    // Two commands back to back while the buffer cannot drain.
    hold = 1'b1;
    cq.push_back({32'h0000_1000, 16'h0004, 1'b1});
    cq.push_back({32'h0002_0F00, 16'h0001, 1'b1});
    while (cq.size() != 0) @(negedge core_clk_in);
    @(negedge core_clk_in);
    chk_bit("request_n", 1'b0, req_n);
    chk_bit("queued_n", 1'b0, qreq_n);
    chk_bit("dir_read", 1'b1, dir_rd);
    repeat (40) @(negedge core_clk_in);
    hold = 1'b0;
    seed = 32'h8f897b4d;
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      cq.push_back({seed, 13'h0000, seed[2:0], 1'b1});
    end
    while (cq.size() != 0 || exp_data.size() != 0) @(negedge core_clk_in);
    repeat (10) @(negedge core_clk_in);
    end_sim();
  end
endmodule
